// >>> pkg/nvmem_regs.svh
// Register offsets, field layout and reset values of the paged byte memory access logic
`ifndef NVMEM_REGS_SVH
`define NVMEM_REGS_SVH

// ----------------------------------------------------------------
// Register select codes on the three low address bits
// ----------------------------------------------------------------
`define ADDR_W 3
`define ADDR_MEMORY_DATA 3'h4
`define ADDR_PAGE_LOW 3'h5
`define ADDR_PAGE_HIGH 3'h6

// ----------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------
`define DATA_W 8
`define PAGE_W 11
`define PAGE_LOW_W 8
`define PAGE_HIGH_W 3
`define PAGE_HIGH_LSB 8
`define PAGE_TOP_BIT 10
`define COUNT_W 7
`define DEV_ADDR_W 17
`define DEV_COUNT 2

// ----------------------------------------------------------------
// Reset values and counter step and end
// ----------------------------------------------------------------
`define PAGE_RESET 11'h000
`define COUNT_RESET 7'h00
`define COUNT_STEP 7'h01
`define COUNT_LAST 7'h7f

`endif

// >>> pkg/nvmem_pkg.sv
// Types shared by the paged byte memory access logic
`include "nvmem_regs.svh"

package nvmem_pkg;

   // Host side pins, sampled together
   typedef struct packed {
      logic [`DATA_W-1:0] data;
      logic [`ADDR_W-1:0] addr;
      logic sel_n;
      logic rd_n;
      logic wr_n;
   } host_bus_t;

   // Strobes toward the two memory devices
   typedef struct packed {
      logic [`DEV_COUNT-1:0] cs_n;
      logic we_n;
      logic oe_n;
   } mem_ctl_t;

endpackage : nvmem_pkg

// >>> verilog/byte_counter.sv
// Seven-bit byte counter with clear and end-of-access increment
`timescale 1ns/1ps
`include "nvmem_regs.svh"

module byte_counter (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Events
   input wire logic clear_i,
   input wire logic cycle_i,
   // Count
   output logic [`COUNT_W-1:0] count_o
);
   import nvmem_pkg::*;

   logic cycle_d_reg;
   logic [`COUNT_W-1:0] count_reg;
   logic [`COUNT_W-1:0] count_next;
   wire cycle_end = cycle_d_reg & ~cycle_i;

   // Clear wins over a coinciding access end; wrap is natural overflow
   assign count_next = clear_i ? `COUNT_RESET :
                       cycle_end ? count_reg + `COUNT_STEP :
                       count_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cycle_d_reg <= 1'b0;
         count_reg <= `COUNT_RESET;
      end else if (ce_i) begin
         cycle_d_reg <= cycle_i;
         count_reg <= count_next;
      end
   end

   assign count_o = count_reg;

endmodule : byte_counter

// >>> verilog/paged_mem_access.sv
// Paged parallel byte memory access: decoder, page register, chip selects
`timescale 1ns/1ps
`include "nvmem_regs.svh"

module paged_mem_access (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   // Host bus pins
   input wire nvmem_pkg::host_bus_t HOST_I,
   input wire logic SYS_RESET_N_I,
   output logic [`DATA_W-1:0] HOST_DATA_O,
   output logic HOST_DATA_OE_O,
   // Memory device pins
   output logic [`DEV_ADDR_W-1:0] MEM_ADDR_O,
   output nvmem_pkg::mem_ctl_t MEM_CTL_O,
   output logic [`DATA_W-1:0] MEM_DATA_O,
   output logic MEM_DATA_OE_O,
   input wire logic [`DATA_W-1:0] MEM_DATA_I
);
   import nvmem_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Pins are asynchronous to REF_CLK_I; only the second stage is read
   host_bus_t host_s1_reg;
   host_bus_t host_s2_reg;
   logic sys_rst_n_s1_reg;
   logic sys_rst_n_s2_reg;
   logic [`DATA_W-1:0] mem_data_s1_reg;
   logic [`DATA_W-1:0] mem_data_s2_reg;

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         host_s1_reg <= '{data: 8'h00, addr: 3'h0, sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
         host_s2_reg <= '{data: 8'h00, addr: 3'h0, sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
         sys_rst_n_s1_reg <= 1'b0;
         sys_rst_n_s2_reg <= 1'b0;
         mem_data_s1_reg <= 8'h00;
         mem_data_s2_reg <= 8'h00;
      end else if (CE_I) begin
         host_s1_reg <= HOST_I;
         host_s2_reg <= host_s1_reg;
         sys_rst_n_s1_reg <= SYS_RESET_N_I;
         sys_rst_n_s2_reg <= sys_rst_n_s1_reg;
         mem_data_s1_reg <= MEM_DATA_I;
         mem_data_s2_reg <= mem_data_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Address decoding
   // ----------------------------------------------------------------
   // One output of the 3-to-8 decode, gated by module select and reset
   function automatic logic decode_hit(
      input logic [`ADDR_W-1:0] addr,
      input logic [`ADDR_W-1:0] code,
      input logic enable
   );
      decode_hit = enable && (addr == code);
   endfunction : decode_hit

   wire decode_en = ~host_s2_reg.sel_n & sys_rst_n_s2_reg;
   wire mem_data_select = decode_hit(host_s2_reg.addr, `ADDR_MEMORY_DATA, decode_en);
   wire page_low_select = decode_hit(host_s2_reg.addr, `ADDR_PAGE_LOW, decode_en);
   wire page_high_select = decode_hit(host_s2_reg.addr, `ADDR_PAGE_HIGH, decode_en);
   wire write_act = ~host_s2_reg.wr_n;
   wire read_act = ~host_s2_reg.rd_n;
   wire page_low_wr = page_low_select & write_act;
   wire page_high_wr = page_high_select & write_act;
   wire mem_read = mem_data_select & read_act & ~write_act;
   wire mem_write = mem_data_select & write_act;
   wire mem_cycle = mem_read | mem_write;

   // ----------------------------------------------------------------
   // Page register
   // ----------------------------------------------------------------
   logic [`PAGE_W-1:0] page_reg;
   logic [`PAGE_W-1:0] page_next;

   // Both halves may be written in any order; the low write also restarts the byte count
   assign page_next = {
      page_high_wr ? host_s2_reg.data[`PAGE_HIGH_W-1:0] : page_reg[`PAGE_W-1:`PAGE_HIGH_LSB],
      page_low_wr ? host_s2_reg.data : page_reg[`PAGE_LOW_W-1:0]
   };

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         page_reg <= `PAGE_RESET;
      end else if (CE_I) begin
         page_reg <= page_next;
      end
   end

   // ----------------------------------------------------------------
   // Byte counter
   // ----------------------------------------------------------------
   logic mem_cycle_reg;
   logic [`COUNT_W-1:0] count;

   // Fed by the registered strobe so the address moves one cycle after
   // the chip select has gone away, giving the devices address hold time
   byte_counter u_byte_counter (
      .clk_i (REF_CLK_I),
      .rst_n_i (RSTN_I),
      .ce_i (CE_I),
      .clear_i (page_low_wr),
      .cycle_i (mem_cycle_reg),
      .count_o (count)
   );

   // ----------------------------------------------------------------
   // Memory device strobes and data
   // ----------------------------------------------------------------
   wire page_top = page_reg[`PAGE_TOP_BIT];
   mem_ctl_t mem_ctl_reg;
   mem_ctl_t mem_ctl_next;
   logic [`DATA_W-1:0] mem_data_reg;
   logic mem_data_oe_reg;
   logic [`DATA_W-1:0] host_data_reg;
   logic host_data_oe_reg;

   // Pages below 1024 on device 0, the rest on device 1
   assign mem_ctl_next.cs_n = ~{mem_cycle & page_top, mem_cycle & ~page_top};
   assign mem_ctl_next.we_n = ~mem_write;
   assign mem_ctl_next.oe_n = ~mem_read;

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         mem_ctl_reg <= '{cs_n: 2'h3, we_n: 1'b1, oe_n: 1'b1};
         mem_cycle_reg <= 1'b0;
         mem_data_reg <= 8'h00;
         mem_data_oe_reg <= 1'b0;
         host_data_reg <= 8'h00;
         host_data_oe_reg <= 1'b0;
      end else if (CE_I) begin
         mem_ctl_reg <= mem_ctl_next;
         mem_cycle_reg <= mem_cycle;
         mem_data_reg <= host_s2_reg.data;
         mem_data_oe_reg <= mem_write;
         host_data_reg <= mem_data_s2_reg;
         host_data_oe_reg <= mem_read;
      end
   end

   // 17-bit device address: ten page bits over the seven count bits
   assign MEM_ADDR_O = {page_reg[`PAGE_TOP_BIT-1:0], count};
   assign MEM_CTL_O = mem_ctl_reg;
   assign MEM_DATA_O = mem_data_reg;
   assign MEM_DATA_OE_O = mem_data_oe_reg;
   assign HOST_DATA_O = host_data_reg;
   assign HOST_DATA_OE_O = host_data_oe_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_reset_blocks_decode;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      !sys_rst_n_s2_reg |-> !mem_data_select && !page_low_select && !page_high_select;
   endproperty
   a_reset_blocks_decode: assert property (p_reset_blocks_decode)
      else $error("decode active during system reset");

   property p_select_addr;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (mem_data_select || page_low_select || page_high_select) |->
         !host_s2_reg.sel_n && host_s2_reg.addr >= 3'h4 && host_s2_reg.addr <= 3'h6;
   endproperty
   a_select_addr: assert property (p_select_addr)
      else $error("select outside addresses 4 to 6 or module select high");

   property p_page_low_latch;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && page_low_wr |=> page_reg[7:0] == $past(host_s2_reg.data) && count == 7'h00;
   endproperty
   a_page_low_latch: assert property (p_page_low_latch)
      else $error("low page write did not latch byte or clear count");

   property p_page_high_latch;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && page_high_wr && !page_low_wr |=>
         page_reg[10:8] == $past(host_s2_reg.data[2:0]) && page_reg[7:0] == $past(page_reg[7:0]);
   endproperty
   a_page_high_latch: assert property (p_page_high_latch)
      else $error("high page write wrong");

   property p_page_hold;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      !page_low_wr && !page_high_wr |=> $stable(page_reg);
   endproperty
   a_page_hold: assert property (p_page_hold)
      else $error("page register changed without a write");

   property p_count_clear;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && page_low_wr ##1 CE_I && !page_low_wr && !mem_cycle_reg |=> count == 7'h00;
   endproperty
   a_count_clear: assert property (p_count_clear)
      else $error("byte counter not cleared by low page write");

   property p_count_step;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && $fell(mem_cycle_reg) && !page_low_wr |=>
         count == 7'($past(count) + 7'h01) && $stable(page_reg[10:8]);
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("byte counter did not step at end of access");

   property p_count_still;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      mem_cycle_reg && mem_cycle && !page_low_wr ##1 mem_cycle_reg |-> $stable(MEM_ADDR_O);
   endproperty
   a_count_still: assert property (p_count_still)
      else $error("device address moved during an access");

   property p_chip_select;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && mem_cycle |=> MEM_CTL_O.cs_n == ($past(page_reg[10]) ? 2'h1 : 2'h2);
   endproperty
   a_chip_select: assert property (p_chip_select)
      else $error("wrong chip select for page");

   property p_strobes;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      !MEM_CTL_O.we_n || !MEM_CTL_O.oe_n |->
         MEM_CTL_O.we_n != MEM_CTL_O.oe_n && MEM_CTL_O.cs_n != 2'h3;
   endproperty
   a_strobes: assert property (p_strobes)
      else $error("device strobe without chip select or both strobes");

   property p_one_device;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      MEM_CTL_O.cs_n != 2'h0;
   endproperty
   a_one_device: assert property (p_one_device)
      else $error("both memory devices selected at once");

   property p_count_wrap;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && $fell(mem_cycle_reg) && !page_low_wr && !page_high_wr && count == 7'h7f |=>
         count == 7'h00 && $stable(page_reg);
   endproperty
   a_count_wrap: assert property (p_count_wrap)
      else $error("byte counter did not wrap to zero with page kept");

   property p_low_keeps_high;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && page_low_wr && !page_high_wr |=> page_reg[10:8] == $past(page_reg[10:8]);
   endproperty
   a_low_keeps_high: assert property (p_low_keeps_high)
      else $error("low page write disturbed the high page part");

   property p_freeze;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      !CE_I |=> $stable(page_reg) && $stable(count) && $stable(MEM_CTL_O);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while the clock enable was low");

   // ----------------------------------------------------------------
   // Bus drive checks
   // ----------------------------------------------------------------
   // Strobe and drive outputs lag the synchronised pins by one edge
   property p_idle_quiet;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && !mem_cycle |=> MEM_CTL_O.cs_n == 2'h3 && !MEM_DATA_OE_O && !HOST_DATA_OE_O;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("device strobed or bus driven outside a data access");

   property p_sys_reset_quiet;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && !sys_rst_n_s2_reg |=> MEM_CTL_O.cs_n == 2'h3 && $stable(page_reg);
   endproperty
   a_sys_reset_quiet: assert property (p_sys_reset_quiet)
      else $error("device selected or page changed during system reset");

   property p_write_data;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && mem_write |=>
         MEM_DATA_OE_O && MEM_DATA_O == $past(host_s2_reg.data) && MEM_CTL_O.oe_n;
   endproperty
   a_write_data: assert property (p_write_data)
      else $error("write access did not drive its byte toward the device");

   property p_read_drive;
      @(posedge REF_CLK_I) disable iff (!RSTN_I)
      CE_I && mem_read |=> HOST_DATA_OE_O && !MEM_DATA_OE_O && MEM_CTL_O.we_n;
   endproperty
   a_read_drive: assert property (p_read_drive)
      else $error("read access did not drive the host bus");

   c_page_write: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      page_high_wr ##[1:20] page_low_wr);
   c_upper_device: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      !MEM_CTL_O.cs_n[1] && !MEM_CTL_O.we_n);
   c_wrap: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      count == 7'h7f ##[1:20] count == 7'h00);
   c_read_lower: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      !MEM_CTL_O.cs_n[0] && !MEM_CTL_O.oe_n);
   c_sys_reset_block: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      !sys_rst_n_s2_reg && !host_s2_reg.sel_n && !host_s2_reg.wr_n);

endmodule : paged_mem_access

// >>> testbench/mem_pair_model.sv
// Behavioural pair of byte-wide memory devices behind the chip selects
`timescale 1ns/1ps
`include "nvmem_regs.svh"

module mem_pair_model (
   // Clock
   input wire logic clk_i,
   // Device pins
   input wire nvmem_pkg::mem_ctl_t ctl_i,
   input wire logic [`DEV_ADDR_W-1:0] addr_i,
   input wire logic [`DATA_W-1:0] data_i,
   input wire logic data_oe_i,
   output logic [`DATA_W-1:0] data_o
);
   import nvmem_pkg::*;
   logic [`DATA_W-1:0] mem [2**(`DEV_ADDR_W+1)];
   wire logic sel = (ctl_i.cs_n != 2'b11);
   // Top key bit picks the device, so the two halves never alias
   wire logic [`DEV_ADDR_W:0] key = {ctl_i.cs_n[0], addr_i};
   initial data_o = 8'h00;
   always @(posedge clk_i) begin
      if (sel && !ctl_i.we_n && data_oe_i) begin
         mem[key] <= data_i;
      end
      // Released bus toggles so a stale byte cannot pass for data
      if (sel && !ctl_i.oe_n) begin
         data_o <= mem[key];
      end else begin
         data_o <= ~data_o;
      end
   end
endmodule : mem_pair_model

// >>> testbench/tb_paged_mem_access.sv
// Self-checking bench for the paged byte memory access logic
`timescale 1ns/1ps
`include "nvmem_regs.svh"

module tb_paged_mem_access;
   import nvmem_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sys_n = 1'b0;
   host_bus_t host = '{8'h00, 3'h0, 1'b1, 1'b1, 1'b1};
   logic [7:0] host_data;
   logic host_oe;
   logic [16:0] mem_addr;
   mem_ctl_t mem_ctl;
   logic [7:0] wdata;
   logic wdata_oe;
   logic [7:0] rdata;
   logic [3:0] ctl_seen;
   logic [7:0] rd_seen;
   logic oe_seen;
   logic [8:0] wr_seen;
   logic ce = 1'b1;
   logic [2:0] bad [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;

   paged_mem_access i_dut (.REF_CLK_I(clk), .RSTN_I(rst_n), .CE_I(ce),
      .HOST_I(host), .SYS_RESET_N_I(sys_n), .HOST_DATA_O(host_data),
      .HOST_DATA_OE_O(host_oe), .MEM_ADDR_O(mem_addr), .MEM_CTL_O(mem_ctl),
      .MEM_DATA_O(wdata), .MEM_DATA_OE_O(wdata_oe), .MEM_DATA_I(rdata));
   mem_pair_model i_mem (.clk_i(clk), .ctl_i(mem_ctl), .addr_i(mem_addr),
      .data_i(wdata), .data_oe_i(wdata_oe), .data_o(rdata));

   initial forever #25 clk = ~clk;

   // ----------------------------------------------------------------
   // Host access and comparison
   // ----------------------------------------------------------------
   // Strobe held 8 cycles so the two-stage synchroniser and read path settle
   task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic wr);
      @(negedge clk);
      host.addr = a;
      host.data = d;
      host.wr_n = !wr;
      host.rd_n = wr;
      repeat (8) @(negedge clk);
      ctl_seen = mem_ctl;
      rd_seen = host_data;
      oe_seen = host_oe;
      wr_seen = {wdata_oe, wdata};
      host.wr_n = 1'b1;
      host.rd_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask : acc

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      sys_n = 1'b1;
      host.sel_n = 1'b0;
      repeat (3) @(negedge clk);
      check(17'(mem_ctl), 17'hf);
      check(mem_addr, 17'h0);
      // Page 0x512: high write keeps three bits, top bit picks device 1
      acc(3'h6, 8'hfd, 1'b1);
      acc(3'h5, 8'h12, 1'b1);
      check(mem_addr, {10'h112, 7'h00});
      for (int i = 0; i < 3; i++) begin
         acc(3'h4, 8'ha0 + 8'(i), 1'b1);
         check(17'(ctl_seen), 17'h5);
         check(17'(wr_seen), 17'({1'b1, 8'ha0 + 8'(i)}));
         check(17'(oe_seen), 17'h0);
         check(mem_addr, {10'h112, 7'(i + 1)});
      end
      acc(3'h5, 8'h12, 1'b1);
      check(mem_addr, {10'h112, 7'h00});
      for (int i = 0; i < 3; i++) begin
         acc(3'h4, 8'h00, 1'b0);
         check(17'(ctl_seen), 17'h6);
         check(17'(oe_seen), 17'h1);
         check(17'(wr_seen[8]), 17'h0);
         check(17'(rd_seen), 17'(8'ha0 + 8'(i)));
      end
      // Page 0x012 lands in the other device, leaving the page 0x512 bytes intact
      acc(3'h6, 8'h00, 1'b1);
      acc(3'h5, 8'h12, 1'b1);
      acc(3'h4, 8'h5c, 1'b1);
      check(17'(ctl_seen), 17'h9);
      acc(3'h5, 8'h12, 1'b1);
      acc(3'h4, 8'h00, 1'b0);
      check(17'(ctl_seen), 17'ha);
      check(17'(rd_seen), 17'h5c);
      acc(3'h6, 8'h05, 1'b1);
      acc(3'h5, 8'h12, 1'b1);
      acc(3'h4, 8'h00, 1'b0);
      check(17'(rd_seen), 17'ha0);
      // Full page of reads wraps the counter, page untouched
      acc(3'h5, 8'h12, 1'b1);
      for (int i = 0; i < 128; i++) begin
         acc(3'h4, 8'h00, 1'b0);
      end
      check(mem_addr, {10'h112, 7'h00});
      check(17'(ctl_seen), 17'h6);
      acc(3'h4, 8'h00, 1'b0);
      check(17'(rd_seen), 17'ha0);
      // Unused addresses, module deselected and system reset all ignored
      foreach (bad[k]) begin
         acc(bad[k], 8'h77, 1'b1);
         check(17'(ctl_seen), 17'hf);
         check(mem_addr, {10'h112, 7'h01});
      end
      host.sel_n = 1'b1;
      acc(3'h5, 8'h33, 1'b1);
      acc(3'h4, 8'h33, 1'b1);
      check(17'(ctl_seen), 17'hf);
      check(mem_addr, {10'h112, 7'h01});
      host.sel_n = 1'b0;
      sys_n = 1'b0;
      repeat (3) @(negedge clk);
      acc(3'h5, 8'h44, 1'b1);
      acc(3'h4, 8'h44, 1'b1);
      check(17'(ctl_seen), 17'hf);
      check(mem_addr, {10'h112, 7'h01});
      sys_n = 1'b1;
      repeat (3) @(negedge clk);
      // Clock enable low: a low page write must leave page and count alone
      ce = 1'b0;
      acc(3'h5, 8'h66, 1'b1);
      check(mem_addr, {10'h112, 7'h01});
      check(17'(ctl_seen), 17'hf);
      ce = 1'b1;
      acc(3'h4, 8'h00, 1'b0);
      check(17'(rd_seen), 17'ha1);
      conclude();
   end
endmodule : tb_paged_mem_access
